//--- hw/fmt_device.sv
`timescale 1ns/1ps
`include "fmt_cfg.svh"
module fmt_device #(
    parameter int  SPT        = 63,
    parameter logic [27:0] NATIVE_MAX = `NATIVE_MAX_LBA
) (
    input  wire logic     clock_i,
    input  wire logic     reset_i,
    fmt_if.dev_end        bus,
    output logic          media_we_o,
    output logic [27:0]   media_lba_o,
    output logic [7:0]    media_data_o,
    output logic          lists_merge_o,
    output logic          lists_commit_o
);
    typedef enum logic [2:0] {S_IDLE, S_TRACK, S_MERGE, S_UNIT, S_DONE} st_t;

    st_t          state, next_state;
    logic [27:0]  lba, next_lba;
    logic [27:0]  last, next_last;
    logic         prepared, next_prepared;
    logic [7:0]   status, next_status;
    logic [7:0]   error, next_error;
    logic         done, next_done;
    logic         we, next_we;
    logic         merge, next_merge;
    logic         commit, next_commit;
    logic [7:0]   ret_low, next_ret_low;
    logic [7:0]   ret_mid, next_ret_mid;
    logic [7:0]   ret_high, next_ret_high;
    logic [7:0]   ret_dev, next_ret_dev;

    function automatic fmt_pkg::op_t decode(input logic [7:0] opc);
        case (opc)
            `OPC_FORMAT_TRACK: decode = fmt_pkg::OP_TRACK;
            `OPC_FORMAT_UNIT:  decode = fmt_pkg::OP_UNIT;
            default:           decode = fmt_pkg::OP_OTHER;
        endcase
    endfunction

    function automatic logic [27:0] track_start(input logic [27:0] a);
        track_start = 28'(a - (a % SPT));
    endfunction

    // Either addressing scheme folds into one linear sector address
    function automatic logic [27:0] target_addr(input fmt_pkg::cmd_block_t c);
        if (c.device[6])
            target_addr = {c.device[3:0], c.lba_high, c.lba_mid, c.lba_low};
        else
            target_addr = 28'(({c.lba_high, c.lba_mid} * 16 + c.device[3:0]) * SPT);
    endfunction

    // Request bit never rises: neither format has a data phase
    function automatic logic [7:0] end_status(input logic [7:0] err);
        end_status                     = 8'h00;
        end_status[`ST_BIT_READY]      = 1'b1;
        end_status[`ST_BIT_SEEK_DONE]  = 1'b1;
        end_status[`ST_BIT_DRQ]        = 1'b0;
        end_status[`ST_BIT_ERR]        = |err;
    endfunction

    always_comb begin
        logic [27:0] addr;
        addr           = 28'h000_0000;
        next_state     = state;
        next_lba       = lba;
        next_last      = last;
        next_prepared  = prepared;
        next_status    = status;
        next_error     = error;
        next_done      = 1'b0;
        next_we        = 1'b0;
        next_merge     = 1'b0;
        next_commit    = 1'b0;
        next_ret_low   = ret_low;
        next_ret_mid   = ret_mid;
        next_ret_high  = ret_high;
        next_ret_dev   = ret_dev;
        case (state)
            S_IDLE: begin
                if (bus.cmd_valid) begin
                    next_status = 8'h00;
                    next_status[`ST_BIT_BUSY] = 1'b1;
                    next_error  = 8'h00;
                    // Address registers read back zero unless an LBA-mode track sets them
                    next_ret_low  = 8'h00;
                    next_ret_mid  = 8'h00;
                    next_ret_high = 8'h00;
                    next_ret_dev  = 8'h00;
                    // Only a directly preceding prepare counts
                    next_prepared = (bus.cmd.command == `OPC_ERASE_PREPARE);
                    case (decode(bus.cmd.command))
                        fmt_pkg::OP_TRACK: begin
                            addr = target_addr(bus.cmd);
                            if (bus.cmd.device[6]) begin
                                next_ret_low  = addr[7:0];
                                next_ret_mid  = addr[15:8];
                                next_ret_high = addr[23:16];
                                next_ret_dev  = {4'h4, addr[27:24]};
                            end
                            next_lba  = track_start(addr);
                            next_last = 28'(track_start(addr) + SPT - 1);
                            if (next_last > NATIVE_MAX) begin
                                next_error[`ERR_BIT_IDNF] = 1'b1;
                                next_state = S_DONE;
                            end else begin
                                next_state = S_TRACK;
                            end
                        end
                        fmt_pkg::OP_UNIT: begin
                            if (!prepared || bus.cmd.feature != `FEAT_MERGE_DEFECTS) begin
                                next_error[`ERR_BIT_ABORT] = 1'b1;
                                next_state = S_DONE;
                            end else begin
                                next_state = S_MERGE;
                            end
                        end
                        default: next_state = S_DONE;
                    endcase
                end
            end
            S_TRACK: begin
                next_we  = 1'b1;
                next_lba = 28'(lba + 1);
                if (lba == last)
                    next_state = S_DONE;
            end
            S_MERGE: begin
                next_merge = 1'b1;
                next_lba   = 28'h000_0000;
                next_last  = NATIVE_MAX;
                next_state = S_UNIT;
            end
            S_UNIT: begin
                next_we  = 1'b1;
                next_lba = 28'(lba + 1);
                if (lba == last) begin
                    next_commit = 1'b1;
                    next_state  = S_DONE;
                end
            end
            S_DONE: begin
                next_done   = 1'b1;
                next_status = end_status(error);
                next_state  = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state    <= S_IDLE;
            lba      <= 28'h000_0000;
            last     <= 28'h000_0000;
            prepared <= 1'b0;
            status   <= `STATUS_RESET;
            error    <= 8'h00;
            done     <= 1'b0;
            we       <= 1'b0;
            merge    <= 1'b0;
            commit   <= 1'b0;
            ret_low  <= 8'h00;
            ret_mid  <= 8'h00;
            ret_high <= 8'h00;
            ret_dev  <= 8'h00;
        end else begin
            state    <= next_state;
            lba      <= next_lba;
            last     <= next_last;
            prepared <= next_prepared;
            status   <= next_status;
            error    <= next_error;
            done     <= next_done;
            we       <= next_we;
            merge    <= next_merge;
            commit   <= next_commit;
            ret_low  <= next_ret_low;
            ret_mid  <= next_ret_mid;
            ret_high <= next_ret_high;
            ret_dev  <= next_ret_dev;
        end
    end

    // Address of the write in flight, one cycle behind the counter
    logic [27:0] wr_lba;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i)
            wr_lba <= 28'h000_0000;
        else
            wr_lba <= lba;
    end

    assign media_we_o     = we;
    assign media_lba_o    = wr_lba;
    assign media_data_o   = 8'h00;
    assign lists_merge_o  = merge;
    assign lists_commit_o = commit;
    assign bus.done       = done;
    assign bus.status     = status;
    assign bus.error      = error;
    assign bus.lba_low    = ret_low;
    assign bus.lba_mid    = ret_mid;
    assign bus.lba_high   = ret_high;
    assign bus.device     = ret_dev;
endmodule

//--- hw/fmt_cfg.svh
`ifndef FMT_CFG_SVH
`define FMT_CFG_SVH
`define OPC_FORMAT_TRACK    8'h50
`define OPC_FORMAT_UNIT     8'hF7
`define OPC_ERASE_PREPARE   8'hF3
`define FEAT_MERGE_DEFECTS  8'h11
`define ERR_BIT_ABORT       2
`define ERR_BIT_IDNF        4
`define ST_BIT_BUSY         7
`define ST_BIT_READY        6
`define ST_BIT_SEEK_DONE    4
`define ST_BIT_DRQ          3
`define ST_BIT_ERR          0
`define SECTORS_PER_TRACK   8'h3F
`define NATIVE_MAX_LBA      28'h000_0FFF
`define STATUS_RESET        8'h50
`endif

//--- hw/fmt_pkg.sv
package fmt_pkg;
    typedef enum logic [1:0] {
        OP_NONE,
        OP_TRACK,
        OP_UNIT,
        OP_OTHER
    } op_t;
    typedef struct packed {
        logic [7:0] feature;
        logic [7:0] lba_low;
        logic [7:0] lba_mid;
        logic [7:0] lba_high;
        logic [7:0] device;
        logic [7:0] command;
    } cmd_block_t;
endpackage

//--- hw/fmt_if.sv
`timescale 1ns/1ps
interface fmt_if;
    logic                  cmd_valid;
    fmt_pkg::cmd_block_t   cmd;
    logic                  done;
    logic [7:0]            status;
    logic [7:0]            error;
    logic [7:0]            lba_low;
    logic [7:0]            lba_mid;
    logic [7:0]            lba_high;
    logic [7:0]            device;
    modport host_end (output cmd_valid, output cmd, input done, input status,
                      input error, input lba_low, input lba_mid, input lba_high,
                      input device);
    modport dev_end  (input cmd_valid, input cmd, output done, output status,
                      output error, output lba_low, output lba_mid, output lba_high,
                      output device);
endinterface

//--- hw/fmt_host.sv
`timescale 1ns/1ps
`include "fmt_cfg.svh"
module fmt_host (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    fmt_if.host_end          bus,
    input  wire logic        req_i,
    input  wire logic [7:0]  opcode_i,
    input  wire logic [7:0]  feature_i,
    input  wire logic        lba_mode_i,
    input  wire logic [27:0] lba_i,
    input  wire logic [15:0] cylinder_i,
    input  wire logic [3:0]  head_i,
    output logic             busy_o,
    output logic             done_o,
    output logic [7:0]       status_o,
    output logic [7:0]       error_o,
    output logic [27:0]      lba_o
);
    logic                 busy, next_busy;
    logic                 valid, next_valid;
    fmt_pkg::cmd_block_t  cmd, next_cmd;
    logic                 done, next_done;
    logic [7:0]           status, next_status;
    logic [7:0]           error, next_error;
    logic [27:0]          lba, next_lba;

    always_comb begin
        next_busy   = busy;
        next_valid  = 1'b0;
        next_cmd    = cmd;
        next_done   = 1'b0;
        next_status = status;
        next_error  = error;
        next_lba    = lba;
        if (!busy && req_i) begin
            next_busy  = 1'b1;
            next_valid = 1'b1;
            next_cmd.command = opcode_i;
            next_cmd.feature = feature_i;
            if (lba_mode_i) begin
                next_cmd.lba_low  = lba_i[7:0];
                next_cmd.lba_mid  = lba_i[15:8];
                next_cmd.lba_high = lba_i[23:16];
                next_cmd.device   = {4'hE, lba_i[27:24]};
            end else begin
                next_cmd.lba_low  = 8'h00;
                next_cmd.lba_mid  = cylinder_i[7:0];
                next_cmd.lba_high = cylinder_i[15:8];
                next_cmd.device   = {4'hA, head_i};
            end
        end else if (busy && bus.done) begin
            next_busy   = 1'b0;
            next_done   = 1'b1;
            next_status = bus.status;
            next_error  = bus.error;
            next_lba    = {bus.device[3:0], bus.lba_high, bus.lba_mid, bus.lba_low};
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            busy   <= 1'b0;
            valid  <= 1'b0;
            cmd    <= '0;
            done   <= 1'b0;
            status <= 8'h00;
            error  <= 8'h00;
            lba    <= 28'h000_0000;
        end else begin
            busy   <= next_busy;
            valid  <= next_valid;
            cmd    <= next_cmd;
            done   <= next_done;
            status <= next_status;
            error  <= next_error;
            lba    <= next_lba;
        end
    end

    assign bus.cmd_valid = valid;
    assign bus.cmd       = cmd;
    assign busy_o        = busy;
    assign done_o        = done;
    assign status_o      = status;
    assign error_o       = error;
    assign lba_o         = lba;
endmodule

//--- tb/fmt_props.sv
`timescale 1ns/1ps
module fmt_props #(
    parameter int SPT = 63
) (
    input wire logic                clock_i,
    input wire logic                reset_i,
    input wire logic                cmd_valid,
    input wire fmt_pkg::cmd_block_t cmd,
    input wire logic                done,
    input wire logic [7:0]          status,
    input wire logic [7:0]          error,
    input wire logic [7:0]          lba_low,
    input wire logic [7:0]          lba_mid,
    input wire logic [7:0]          lba_high,
    input wire logic [7:0]          device
);
    localparam int TRK_MAX = SPT + 3;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    logic       take;
    logic [7:0] last_cmd;
    assign take = cmd_valid && !status[7];
    // Unit format is only legal right after the prepare command
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i)
            last_cmd <= 8'h00;
        else if (take)
            last_cmd <= cmd.command;
    end
    busy_on_take_a: assert property (take |=> status == 8'h80)
        else $error("status not busy after command");
    no_data_phase_a: assert property (!status[3])
        else $error("data request raised");
    other_quick_a: assert property (take && cmd.command != 8'h50 && cmd.command != 8'hF7
        |-> ##[1:2] (done && status == 8'h50 && error == 8'h00))
        else $error("non-format command not finished cleanly");
    feature_abort_a: assert property (take && cmd.command == 8'hF7 && cmd.feature != 8'h11
        |-> ##[1:3] (done && error == 8'h04 && status == 8'h51))
        else $error("bad feature not aborted");
    prepare_abort_a: assert property (take && cmd.command == 8'hF7 && last_cmd != 8'hF3
        |-> ##[1:3] (done && error == 8'h04 && status == 8'h51))
        else $error("unit format without prepare not aborted");
    unit_runs_a: assert property (take && cmd.command == 8'hF7 && cmd.feature == 8'h11
        && last_cmd == 8'hF3 |=> (status == 8'h80)[*8])
        else $error("unit format ended too early");
    track_done_a: assert property (take && cmd.command == 8'h50 |-> ##[1:TRK_MAX] done)
        else $error("track format did not finish in time");
    error_flags_a: assert property (done && error != 8'h00 |-> status[0] && !status[7])
        else $error("error without error status");
    lba_hold_a: assert property (!status[7] && !take
        |=> $stable({device, lba_high, lba_mid, lba_low}))
        else $error("returned address changed while idle");
endmodule

//--- tb/drive_format_command_handler_tb.sv
`timescale 1ns/1ps
module drive_format_command_handler_tb;
    localparam int SPT = 8;
    logic        clock_i, reset_i, req_i, mode, we, mrg, cmt, busy_o, done_o, bad;
    logic [7:0]  opc, feat, status_o, error_o, data;
    logic [27:0] lba, lba_o, maddr, first_a, last_a;
    logic [15:0] cyl;
    logic [3:0]  head;
    fmt_pkg::cmd_block_t seen;
    int fail_count, samples_checked, writes, mrg_n, mrg_w, cmt_n;
    fmt_if bus_if();
    fmt_device #(.SPT(SPT), .NATIVE_MAX(28'h000_007F)) fmt_device_inst (.clock_i(clock_i),
        .reset_i(reset_i), .bus(bus_if), .media_we_o(we), .media_lba_o(maddr),
        .media_data_o(data), .lists_merge_o(mrg), .lists_commit_o(cmt));
    fmt_host fmt_host_inst (.clock_i(clock_i), .reset_i(reset_i), .bus(bus_if),
        .req_i(req_i), .opcode_i(opc), .feature_i(feat), .lba_mode_i(mode), .lba_i(lba),
        .cylinder_i(cyl), .head_i(head), .busy_o(busy_o), .done_o(done_o),
        .status_o(status_o), .error_o(error_o), .lba_o(lba_o));
    fmt_props #(.SPT(SPT)) fmt_props_inst (.clock_i(clock_i), .reset_i(reset_i),
        .cmd_valid(bus_if.cmd_valid), .cmd(bus_if.cmd), .done(bus_if.done),
        .status(bus_if.status), .error(bus_if.error), .lba_low(bus_if.lba_low),
        .lba_mid(bus_if.lba_mid), .lba_high(bus_if.lba_high), .device(bus_if.device));
    // Sampled mid-cycle so one-cycle pulses are seen exactly once
    always @(negedge clock_i) begin
        if (we) begin
            if (data !== 8'h00 || (writes > 0 && maddr !== last_a + 28'h000_0001))
                bad = 1'b1;
            if (writes == 0)
                first_a = maddr;
            last_a = maddr;
            writes++;
        end
        if (mrg) begin
            mrg_n++;
            mrg_w = writes;
        end
        if (cmt)
            cmt_n++;
        if (bus_if.cmd_valid)
            seen = bus_if.cmd;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [7:0] o, input logic [7:0] f, input logic m,
                       input logic [27:0] a, input logic [15:0] c, input logic [3:0] h);
        int n;
        n = 0;
        while (busy_o !== 1'b0) @(negedge clock_i);
        writes = 0; mrg_n = 0; cmt_n = 0; bad = 1'b0;
        req_i = 1'b1; opc = o; feat = f; mode = m; lba = a; cyl = c; head = h;
        @(negedge clock_i);
        req_i = 1'b0;
        while (done_o !== 1'b1 && n < 2000) begin
            @(negedge clock_i);
            n++;
        end
        @(negedge clock_i);
        check(n < 2000, 1);
        $display("test with opcode %0h ended", o);
    endtask
    task automatic res(input logic [7:0] st, input logic [7:0] er, input int n);
        check(status_o, st);
        check(error_o, er);
        check(writes, n);
        check(bad, 1'b0);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    initial begin
        #100000;
        fail_count++;
        summarize();
    end
    initial begin
        reset_i = 1'b1; req_i = 1'b0; opc = 8'h00; feat = 8'h00; mode = 1'b0;
        lba = 28'h000_0000; cyl = 16'h0000; head = 4'h0; bad = 1'b0;
        repeat (12) @(negedge clock_i);
        reset_i = 1'b0;
        run(8'h00, 8'h11, 1'b0, 28'h000_0000, 16'h0000, 4'h0);
        res(8'h50, 8'h00, 0);
        run(8'hF7, 8'h11, 1'b0, 28'h000_0000, 16'h0000, 4'h0);
        res(8'h51, 8'h04, 0);
        run(8'hF3, 8'h00, 1'b0, 28'h000_0000, 16'h0000, 4'h0);
        run(8'hF7, 8'h22, 1'b0, 28'h000_0000, 16'h0000, 4'h0);
        res(8'h51, 8'h04, 0);
        run(8'hF3, 8'h00, 1'b0, 28'h000_0000, 16'h0000, 4'h0);
        run(8'hF7, 8'h11, 1'b0, 28'h000_0000, 16'h0000, 4'h0);
        res(8'h50, 8'h00, 128);
        check(first_a, 28'h000_0000);
        check(last_a, 28'h000_007F);
        check(mrg_n, 32'h0000_0001);
        check(mrg_w, 32'h0000_0000);
        check(cmt_n, 1);
        run(8'h50, 8'h00, 1'b1, 28'h000_0013, 16'h0000, 4'h0);
        res(8'h50, 8'h00, SPT);
        check(first_a, 28'h000_0010);
        check({seen.device[6], seen.device[3:0], seen.lba_high, seen.lba_mid, seen.lba_low},
              {1'b1, 28'h000_0013});
        check(lba_o[27:3], 25'h000_0002);
        run(8'h50, 8'h00, 1'b0, 28'h000_0000, 16'h0000, 4'h3);
        res(8'h50, 8'h00, SPT);
        check(first_a, 28'h000_0018);
        check(lba_o, 28'h000_0000);
        check({seen.device[6], seen.device[3:0], seen.lba_high, seen.lba_mid},
              {1'b0, 4'h3, 16'h0000});
        run(8'h50, 8'h00, 1'b0, 28'h000_0000, 16'h0001, 4'h0);
        res(8'h51, 8'h10, 0);
        summarize();
    end
endmodule
